// ==== verilog/tpsb_top.sv ====
// temperature port sequencer and echo blanking with an axi4-lite register slave
//
// Overview of operation
// - preamble runs dummy cycles equal to three-bit field, zero to seven
// - dummy cycles lie inside the sequence, before the real port measurements
// - blanking delay 0000h to ffffh, one count per 250 ns crystal period
// - no stop condition from echo inputs until blanking delay has elapsed
// - blanking count starts at the internal launch pulse
// - blanking delay gates early edge detection of the received wave
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpsb_consts.svh"
module tpsb_top #(
  parameter int unsigned INTERVAL_BASE_CYCLES = `TPSB_PORT_INTERVAL_BASE_US * `TPSB_CLK_MHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`TPSB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TPSB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic launchPulse,
  input wire logic upstreamEchoInput,
  input wire logic downstreamEchoInput,
  output logic [3:0] measPort,
  output logic measStart,
  output logic dummyActive,
  output logic seqBusy,
  output logic stopDetect,
  output logic stopEnable
);
  import tpsb_pkg::*;
  tpsb_top_s r;
  tpsb_top_s n;
  tpsb_blank_if blk ();
  logic [1:0] echoEdge;

  // one-hot port for a slot; order is a, c, b, d (bit0=a .. bit3=d)
  function automatic logic [3:0] portAt(input logic [1:0] sel, input logic [1:0] idx);
    logic [3:0] p;
    p = 4'h0;
    case (sel)
      2'h0: p = (idx == 2'h0) ? 4'h1 : 4'h4;
      2'h1: p = (idx == 2'h0) ? 4'h2 : 4'h8;
      default: begin
        case (idx)
          2'h0: p = 4'h1;
          2'h1: p = 4'h4;
          2'h2: p = 4'h2;
          default: p = 4'h8;
        endcase
      end
    endcase
    return p;
  endfunction

  // index of the last real port slot for a selection
  function automatic logic [1:0] lastSlot(input logic [1:0] sel);
    logic [1:0] s;
    s = 2'h1;
    case (sel)
      2'h2: s = 2'h2;
      2'h3: s = 2'h3;
      default: s = 2'h1;
    endcase
    return s;
  endfunction

  // start-to-start length less one, counted in system clocks
  function automatic logic [`TPSB_INTERVAL_W-1:0] slotLen(input logic [1:0] sel);
    return `TPSB_INTERVAL_W'(INTERVAL_BASE_CYCLES * ({30'h0, sel} + 32'h1) - 32'h1);
  endfunction

  // word decode shared by the write and read paths; msb is the hit flag
  function automatic logic [2:0] decode(input logic [`TPSB_ADDR_W-1:0] a);
    return {(a[`TPSB_ADDR_W-1:4] == '0), a[3:2]};
  endfunction

  // byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [15:0] m;
    m = old;
    if (s[0]) m[7:0] = d[7:0];
    if (s[1]) m[15:8] = d[15:8];
    return m;
  endfunction

  assign echoEdge = r.echoSync2 & ~r.echoPrev;

  always_comb begin
    logic [2:0] wdec;
    logic [2:0] rdec;
    logic [15:0] ctlWord;
    logic [1:0] tp;
    logic [2:0] pre;
    logic [1:0] pc;
    logic startSeq;
    logic swLaunch;
    logic clrStop;
    wdec = 3'h0;
    rdec = 3'h0;
    ctlWord = 16'h0000;
    startSeq = 1'b0;
    swLaunch = 1'b0;
    clrStop = 1'b0;
    tp = r.cfg[`TPSB_TP_HI:`TPSB_TP_LO];
    pre = r.cfg[`TPSB_PRE_HI:`TPSB_PRE_LO];
    pc = r.cfg[`TPSB_PORTCYC_HI:`TPSB_PORTCYC_LO];
    n = r;
    n.measStart = 1'b0;
    n.stopDetect = 1'b0;
    n.launch = 1'b0;

    // write channel: address and data taken in either order, response after both
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (s_axi_awvalid && r.awReady) begin
      n.awHeld = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wReady) begin
      n.wHeld = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (n.awHeld && n.wHeld && !n.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `TPSB_RESP_OKAY;
      wdec = decode(n.awAddr);
      if (!wdec[2]) begin
        n.bresp = `TPSB_RESP_SLVERR;
      end else begin
        case ({4'h0, wdec[1:0], 2'b00})
          `TPSB_OFS_CFG: n.cfg = merge(r.cfg, n.wData, n.wStrb);
          `TPSB_OFS_DLY: n.dly = merge(r.dly, n.wData, n.wStrb);
          `TPSB_OFS_CTL: begin
            ctlWord = merge(16'h0000, n.wData, n.wStrb);
            startSeq = ctlWord[`TPSB_CTL_START];
            swLaunch = ctlWord[`TPSB_CTL_LAUNCH];
            clrStop = ctlWord[`TPSB_CTL_CLRSTOP];
          end
          default: ;
        endcase
      end
    end

    // read channel: one cycle from address to data, control reads zero
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && r.arReady) begin
      rdec = decode(s_axi_araddr);
      n.rvalid = 1'b1;
      n.rresp = rdec[2] ? `TPSB_RESP_OKAY : `TPSB_RESP_SLVERR;
      n.rdata = 32'h0000_0000;
      if (rdec[2]) begin
        case ({4'h0, rdec[1:0], 2'b00})
          `TPSB_OFS_CFG: n.rdata = {16'h0000, r.cfg};
          `TPSB_OFS_DLY: n.rdata = {16'h0000, r.dly};
          `TPSB_OFS_STAT: n.rdata = {23'h0, r.dummyActive, r.dummyLeft, r.slot, r.stopSeen,
                                     blk.stopEnable, r.seqBusy};
          default: n.rdata = 32'h0000_0000;
        endcase
      end
    end
    n.awReady = !n.awHeld && !n.bvalid;
    n.wReady = !n.wHeld && !n.bvalid;
    n.arReady = !n.rvalid;

    // sequencer: dummy slots first, then the selected ports, one interval each
    case (r.seq)
      SEQ_IDLE: begin
        if (startSeq) begin
          n.seqBusy = 1'b1;
          n.slot = 2'h0;
          n.dummyLeft = pre;
          n.intervalCnt = slotLen(pc);
          n.measStart = 1'b1;
          n.measPort = portAt(tp, 2'h0);
          n.dummyActive = (pre != 3'h0);
          n.seq = (pre != 3'h0) ? SEQ_DUMMY : SEQ_PORT;
        end
      end
      SEQ_DUMMY: begin
        if (r.intervalCnt != '0) begin
          n.intervalCnt = r.intervalCnt - 20'h00001;
        end else begin
          n.intervalCnt = slotLen(pc);
          n.measStart = 1'b1;
          n.dummyLeft = r.dummyLeft - 3'h1;
          if (r.dummyLeft == 3'h1) begin
            n.dummyActive = 1'b0;
            n.seq = SEQ_PORT;
          end
        end
      end
      SEQ_PORT: begin
        if (r.intervalCnt != '0) begin
          n.intervalCnt = r.intervalCnt - 20'h00001;
        end else if (r.slot == lastSlot(tp)) begin
          n.seq = SEQ_IDLE;
          n.seqBusy = 1'b0;
          n.measPort = 4'h0;
        end else begin
          n.slot = r.slot + 2'h1;
          n.intervalCnt = slotLen(pc);
          n.measStart = 1'b1;
          n.measPort = portAt(tp, r.slot + 2'h1);
        end
      end
      default: n.seq = SEQ_IDLE;
    endcase

    // echo inputs pass two flops; the second stage and its one-cycle-delayed copy feed edge logic
    n.echoSync1 = {downstreamEchoInput, upstreamEchoInput};
    n.echoSync2 = r.echoSync1;
    n.echoPrev = r.echoSync2;

    // launch arms one stop; a stop edge counts only after blanking
    n.launch = launchPulse | swLaunch;
    if (clrStop) n.stopSeen = 1'b0;
    if (r.launch) begin
      n.stopArmed = 1'b1;
    end else if (r.stopArmed && blk.stopEnable && (echoEdge != 2'h0)) begin
      n.stopArmed = 1'b0;
      n.stopDetect = 1'b1;
      n.stopSeen = 1'b1; // set beats a same-cycle clear
    end
  end

  // single register stage for all state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.cfg <= `TPSB_CFG_RESET;
      r.dly <= `TPSB_DLY_RESET;
    end else begin
      r <= n;
    end
  end

  assign blk.launch = r.launch;
  assign blk.delay = r.dly;

  tpsb_blank u_blank (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(blk)
  );

  assign s_axi_awready = r.awReady;
  assign s_axi_wready = r.wReady;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arReady;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign measPort = r.measPort;
  assign measStart = r.measStart;
  assign dummyActive = r.dummyActive;
  assign seqBusy = r.seqBusy;
  assign stopDetect = r.stopDetect;
  assign stopEnable = blk.stopEnable;
endmodule
`default_nettype wire

// ==== include/tpsb_consts.svh ====
// named constants for the temperature port sequencer and echo blanking block
`ifndef TPSB_CONSTS_SVH
`define TPSB_CONSTS_SVH
`define TPSB_ADDR_W 8
`define TPSB_REG_W 16
`define TPSB_OFS_CFG 8'h00
`define TPSB_OFS_DLY 8'h04
`define TPSB_OFS_CTL 8'h08
`define TPSB_OFS_STAT 8'h0c
`define TPSB_CFG_RESET 16'h0000
`define TPSB_DLY_RESET 16'h0000
`define TPSB_TP_HI 6
`define TPSB_TP_LO 5
`define TPSB_PRE_HI 4
`define TPSB_PRE_LO 2
`define TPSB_PORTCYC_HI 1
`define TPSB_PORTCYC_LO 0
`define TPSB_CTL_START 0
`define TPSB_CTL_LAUNCH 1
`define TPSB_CTL_CLRSTOP 2
`define TPSB_RESP_OKAY 2'h0
`define TPSB_RESP_SLVERR 2'h2
`define TPSB_CLK_MHZ 200
`define TPSB_CLK_PERIOD_NS 5
`define TPSB_CRYSTAL_PERIOD_NS 250
`define TPSB_PORT_INTERVAL_BASE_US 128
`define TPSB_INTERVAL_W 20
`define TPSB_TICK_W 8
`endif

// ==== include/tpsb_pkg.sv ====
// types shared by the sequencer top and the blanking counter
`include "tpsb_consts.svh"
package tpsb_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DUMMY, SEQ_PORT} tpsb_seq_e;

  typedef struct packed {
    logic awReady;
    logic wReady;
    logic arReady;
    logic awHeld;
    logic wHeld;
    logic [`TPSB_ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`TPSB_REG_W-1:0] cfg;
    logic [`TPSB_REG_W-1:0] dly;
    tpsb_seq_e seq;
    logic [1:0] slot;
    logic [2:0] dummyLeft;
    logic [`TPSB_INTERVAL_W-1:0] intervalCnt;
    logic [3:0] measPort;
    logic measStart;
    logic dummyActive;
    logic seqBusy;
    logic [1:0] echoSync1;
    logic [1:0] echoSync2;
    logic [1:0] echoPrev;
    logic launch;
    logic stopArmed;
    logic stopDetect;
    logic stopSeen;
  } tpsb_top_s;

  typedef struct packed {
    logic [`TPSB_TICK_W-1:0] tick;
    logic [`TPSB_REG_W-1:0] count;
    logic blanking;
    logic stopEnable;
  } tpsb_blank_s;
endpackage

// ==== include/tpsb_blank_if.sv ====
// carrier between the register side and the blanking counter
`timescale 1ns/1ps
`default_nettype none
`include "tpsb_consts.svh"
interface tpsb_blank_if;
  logic launch;
  logic [`TPSB_REG_W-1:0] delay;
  logic blanking;
  logic stopEnable;
  modport ctl (output launch, output delay, input blanking, input stopEnable);
  modport core (input launch, input delay, output blanking, output stopEnable);
endinterface
`default_nettype wire

// ==== verilog/tpsb_blank.sv ====
// echo blanking counter in crystal periods from the launch pulse
`timescale 1ns/1ps
`default_nettype none
`include "tpsb_consts.svh"
module tpsb_blank #(
  parameter int unsigned TICK_CYCLES = `TPSB_CRYSTAL_PERIOD_NS / `TPSB_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic sys_rst,
  tpsb_blank_if.core bus
);
  import tpsb_pkg::*;
  tpsb_blank_s r;
  tpsb_blank_s n;

  // prescaler gives one count per crystal period, counter compares against delay
  always_comb begin
    n = r;
    if (bus.launch) begin
      n.tick = '0;
      n.count = '0;
      n.blanking = 1'b1;
      n.stopEnable = 1'b0;
    end else if (r.blanking) begin
      if (r.count == bus.delay) begin
        n.blanking = 1'b0;
        n.stopEnable = 1'b1;
      end else if (r.tick == TICK_CYCLES[`TPSB_TICK_W-1:0] - 8'h01) begin
        n.tick = '0;
        n.count = r.count + 16'h0001;
      end else begin
        n.tick = r.tick + 8'h01;
      end
    end
  end

  // stop detection stays off until the first launch after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.blanking = r.blanking;
  assign bus.stopEnable = r.stopEnable;
endmodule
`default_nettype wire

// ==== verilog/tpsb_fix_note.sv ====
// no logic lives in this file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== test/tpsb_top_monitor.sv ====
// assertions on the sequencer and blanking top ports
`timescale 1ns/1ps
`default_nettype none
`include "tpsb_consts.svh"
module tpsb_top_monitor #(
  parameter int unsigned INTERVAL_BASE_CYCLES = 25600
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`TPSB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic launchPulse,
  input wire logic [3:0] measPort,
  input wire logic measStart,
  input wire logic dummyActive,
  input wire logic seqBusy,
  input wire logic stopDetect,
  input wire logic stopEnable
);
  localparam int TICK = `TPSB_CRYSTAL_PERIOD_NS / `TPSB_CLK_PERIOD_NS;
  logic [15:0] cfgReg;
  logic [15:0] dlyReg;
  logic [23:0] sinceLaunch;
  logic [23:0] gap;
  logic launched;
  logic wrTake;
  logic launchSeen;
  assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // a software launch through the control word acts like the launch pin
  assign launchSeen = launchPulse ||
    (wrTake && s_axi_awaddr == `TPSB_OFS_CTL && s_axi_wdata[`TPSB_CTL_LAUNCH]);
  // shadows assume full-word strobes, which is all the bench issues
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgReg <= 16'h0000;
      dlyReg <= 16'h0000;
      sinceLaunch <= 24'h000000;
      gap <= 24'h000000;
      launched <= 1'b0;
    end else begin
      if (wrTake && s_axi_awaddr == `TPSB_OFS_CFG) cfgReg <= s_axi_wdata[15:0];
      if (wrTake && s_axi_awaddr == `TPSB_OFS_DLY) dlyReg <= s_axi_wdata[15:0];
      sinceLaunch <= launchSeen ? 24'h000000 : sinceLaunch + 24'h000001;
      launched <= launched | launchSeen;
      gap <= measStart ? 24'h000001 : gap + 24'h000001;
    end
  end
  default clocking mcb @(posedge clk); endclocking
  default disable iff (sys_rst);
  port_onehot_a: assert property (seqBusy ? $onehot(measPort) : measPort == 4'h0)
    else $error("measured port not one-hot");
  dummy_first_a: assert property ($rose(seqBusy) |-> measStart &&
    dummyActive == (cfgReg[4:2] != 3'h0)) else $error("sequence start slot wrong");
  dummy_order_a: assert property (seqBusy && !dummyActive |=> !dummyActive)
    else $error("dummy slot after a real port");
  slot_spacing_a: assert property (measStart && $past(seqBusy) |->
    gap == INTERVAL_BASE_CYCLES * (cfgReg[1:0] + 1)) else $error("slot spacing wrong");
  launch_hold_a: assert property (launchSeen && dlyReg != 16'h0000 |-> ##3 !stopEnable [*4])
    else $error("stop enable kept after launch");
  early_release_a: assert property ($rose(stopEnable) |-> launched &&
    sinceLaunch >= TICK * dlyReg) else $error("blanking ended early");
  late_release_a: assert property (launched && sinceLaunch == TICK * dlyReg + 8 |->
    stopEnable) else $error("blanking ended late");
  gated_stop_a: assert property (stopDetect |-> stopEnable || $past(stopEnable))
    else $error("stop seen while blanked");
endmodule
bind tpsb_top tpsb_top_monitor #(.INTERVAL_BASE_CYCLES(INTERVAL_BASE_CYCLES)) mon_u (.*);
`default_nettype wire

// ==== test/tpsb_host_model.sv ====
// host register master on the axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "tpsb_consts.svh"
module tpsb_host_model (
  input wire logic clk,
  output logic [`TPSB_ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [`TPSB_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // bus idle from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
  end
  // released payload is inverted so a late sample never sees the old value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        awDone = 1'b1;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
        wDone = 1'b1;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_tpsb_top.sv ====
// bench: register access, port sequencing, echo blanking
`timescale 1ns/1ps
`default_nettype none
`include "tpsb_consts.svh"
module tb_tpsb_top;
  localparam int unsigned IB = 20;
  localparam int TICK = `TPSB_CRYSTAL_PERIOD_NS / `TPSB_CLK_PERIOD_NS;
  // port order per selection, low nibble first: a=1 b=2 c=4 d=8
  localparam logic [15:0] ORDER [4] = '{16'h0041, 16'h0082, 16'h0241, 16'h8241};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic launchPulse = 1'b0;
  logic upstreamEchoInput = 1'b0;
  logic downstreamEchoInput = 1'b0;
  logic [`TPSB_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, measPort;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic measStart, dummyActive, seqBusy, stopDetect, stopEnable;
  logic [4:0] seen [$];
  int stamp [$];
  int cyc = 0;
  int stops = 0;
  int miscompares = 0;
  int compares = 0;
  tpsb_top #(.INTERVAL_BASE_CYCLES(IB)) dut_u (.*);
  tpsb_host_model host_u (.*);
  always #(`TPSB_CLK_PERIOD_NS / 2.0) clk = ~clk;
  // slot log with cycle stamps, and accepted stop count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (measStart === 1'b1) begin
      seen.push_back({dummyActive, measPort});
      stamp.push_back(cyc);
    end
    if (stopDetect === 1'b1) stops <= stops + 1;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    host_u.rd(a, d, resp);
    chk("read data", d, exp);
    chk("read resp", {30'h0, resp}, {30'h0, er});
  endtask
  // second start lands while busy and must not add slots
  task automatic runSeq(input logic [1:0] tp, input logic [2:0] pre, input logic [1:0] pc);
    logic [4:0] want;
    int n;
    seen.delete();
    stamp.delete();
    host_u.wr(`TPSB_OFS_CFG, {25'h0, tp, pre, pc}, resp);
    host_u.wr(`TPSB_OFS_CTL, 32'h1, resp);
    host_u.wr(`TPSB_OFS_CTL, 32'h1, resp);
    n = 0;
    while (seqBusy !== 1'b0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk("sequence end", {31'h0, seqBusy}, 32'h0);
    chk("slot count", seen.size(), pre + (tp[1] ? 3 + tp[0] : 2));
    for (n = 0; n < seen.size(); n++) begin
      want = n < pre ? {1'b1, ORDER[tp][3:0]} : {1'b0, ORDER[tp][4 * (n - pre) +: 4]};
      chk("slot port", seen[n], want);
      if (n > 0) chk("slot gap", stamp[n] - stamp[n - 1], IB * (pc + 1));
    end
  endtask
  task automatic pulseEcho(input logic dn);
    {downstreamEchoInput, upstreamEchoInput} <= dn ? 2'b10 : 2'b01;
    repeat (10) @(posedge clk);
    {downstreamEchoInput, upstreamEchoInput} <= 2'b00;
    repeat (10) @(posedge clk);
  endtask
  task automatic blank(input logic [15:0] d, input logic dn);
    logic [31:0] st;
    int t0;
    int s0;
    host_u.wr(`TPSB_OFS_DLY, {16'h0, d}, resp);
    s0 = stops;
    t0 = cyc;
    // downstream runs use the software launch bit instead of the pin
    if (dn) begin
      host_u.wr(`TPSB_OFS_CTL, 32'h2, resp);
    end else begin
      launchPulse <= 1'b1;
      @(posedge clk);
      launchPulse <= 1'b0;
    end
    repeat (2 * TICK) @(posedge clk);
    pulseEcho(dn);
    chk("early stop", stops, s0);
    while (cyc - t0 < TICK * d - 20) @(posedge clk);
    chk("enable early", stopEnable, 1'b0);
    while (cyc - t0 < TICK * d + 15) @(posedge clk);
    chk("enable late", stopEnable, 1'b1);
    pulseEcho(dn);
    pulseEcho(dn);
    chk("stop count", stops, s0 + 1);
    host_u.rd(`TPSB_OFS_STAT, st, resp);
    chk("status", st[2:1], 2'b11);
    host_u.wr(`TPSB_OFS_CTL, 32'h4, resp);
    host_u.rd(`TPSB_OFS_STAT, st, resp);
    chk("status clear", st[2:1], 2'b01);
  endtask
  task automatic test_done();
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence; the host keeps every blanking delay at 0012h or more
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdChk(`TPSB_OFS_CFG, 32'h0, `TPSB_RESP_OKAY);
    rdChk(`TPSB_OFS_DLY, 32'h0, `TPSB_RESP_OKAY);
    host_u.wr(`TPSB_OFS_DLY, 32'h0000ffff, resp);
    rdChk(`TPSB_OFS_CTL, 32'h0, `TPSB_RESP_OKAY);
    rdChk(8'h40, 32'h0, `TPSB_RESP_SLVERR);
    host_u.wr(8'h44, 32'h00001234, resp);
    chk("write resp", {30'h0, resp}, {30'h0, `TPSB_RESP_SLVERR});
    rdChk(`TPSB_OFS_DLY, 32'h0000ffff, `TPSB_RESP_OKAY);
    runSeq(2'h0, 3'h0, 2'h0);
    runSeq(2'h1, 3'h7, 2'h1);
    runSeq(2'h2, 3'h3, 2'h2);
    runSeq(2'h3, 3'h1, 2'h3);
    blank(16'h0012, 1'b0);
    blank(16'h0014, 1'b1);
    test_done();
  end
  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge clk); // timeout far past any blanking span
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
